//--- design/output_module_diag_record.sv
// Diagnostic record of a four-channel timestamped digital output module.
// Assumes the head module supplies request strobes on core_clk_in.
// Functional notes
// - Issue queued states in order, drop each.
// - No interrupts; record read on demand only.
// - Full record via set 01h or 2F01h.
// - First four bytes via set 00h, 2F00h.
// - EtherCAT fields as subindices under 5005h.
// - Class low nibble 1111b, default 1Fh.
// - Bit 4 channel info, bits 7-5 reserved.
// - Channel kind 72h, bit 7 zero.
// - Diagnostic bits per channel read 00h.
// - Channel count reads 04h.
// - Timestamp captures ticker at record generation.
`timescale 1ns/1ns
`default_nettype none
`include "diag_record_params.svh"
module output_module_diag_record #(
  parameter int QUEUE_DEPTH = 32
) (
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        read_req_in,
  input  wire logic [1:0]  access_path_in,
  input  wire logic [7:0]  record_set_selector_in,
  input  wire logic [15:0] object_index_in,
  input  wire logic [7:0]  object_subindex_in,
  input  wire logic [5:0]  byte_addr_in,
  input  wire logic        generate_in,
  input  wire logic        entry_push_in,
  input  wire logic [7:0]  output_image_byte_in,
  input  wire logic [7:0]  entry_sequence_number_in,
  input  wire logic [15:0] entry_time_in,
  output logic             read_valid_out,
  output logic             read_error_out,
  output logic [7:0]       read_data_out,
  output logic [3:0]       outputs_out,
  output logic             queue_full_out,
  output logic [5:0]       queued_entry_count_out,
  output logic [7:0]       last_sequence_out,
  output logic             schedule_done_out,
  output logic             irq_out
);
  logic [31:0]  ticker;
  logic [31:0]  diag_timestamp_q;
  logic [7:0]   queued_img;
  logic         issued;
  logic         q_full;
  logic [5:0]   q_count;
  logic [7:0]   q_last;
  logic         q_done;
  logic         gen_meta_q;
  logic         gen_sync_q;
  logic         gen_prev_q;
  logic         push_meta_q;
  logic         push_sync_q;
  logic         push_prev_q;

  us_ticker u_ticker (
    .core_clk_in  (core_clk_in),
    .sys_rst_in   (sys_rst_in),
    .us_count_out (ticker)
  );

  timed_output_queue #(
    .DEPTH (QUEUE_DEPTH)
  ) u_queue (
    .core_clk_in  (core_clk_in),
    .sys_rst_in   (sys_rst_in),
    .push_in      (push_sync_q && !push_prev_q),
    .image_in     (output_image_byte_in),
    .seq_in       (entry_sequence_number_in),
    .time_in      (entry_time_in),
    .now_in       (ticker[15:0]),
    .full_out     (q_full),
    .image_out    (queued_img),
    .issue_out    (issued),
    .last_seq_out (q_last),
    .count_out    (q_count),
    .done_out     (q_done)
  );

  // Byte value of the record at a linear byte position.
  function automatic logic [7:0] record_byte(input logic [5:0] pos, input logic [31:0] ts);
    logic [7:0] b;
    b = `FAULT_RESET;
    case (pos)
      6'd1:    b = {3'b000, 1'b1, `CLASS_DIGITAL};
      6'd4:    b = `KIND_RESET & 8'h7F;
      6'd5:    b = `DIAG_BITS_RESET;
      6'd6:    b = `CH_COUNT_RESET;
      6'd20:   b = ts[7:0];
      6'd21:   b = ts[15:8];
      6'd22:   b = ts[23:16];
      6'd23:   b = ts[31:24];
      default: b = `FAULT_RESET;
    endcase
    return b;
  endfunction

  // Byte position of an EtherCAT subindex; 63 marks an unmapped subindex.
  function automatic logic [5:0] subidx_pos(input logic [7:0] sx, input logic [5:0] part);
    logic [5:0] p;
    p = 6'd63;
    if (sx >= `SUBIDX_FAULT_A && sx <= `SUBIDX_CH_FAULT_HI) begin
      p = 6'(sx - `SUBIDX_FAULT_A);
    end else if (sx == `SUBIDX_TIMESTAMP && part < 6'd4) begin
      p = `TS_BYTE0 + part;
    end
    return p;
  endfunction

  wire is_rs    = (access_path_in == 2'(diag_record_pkg::PATH_RECORD_SET));
  wire is_co    = (access_path_in == 2'(diag_record_pkg::PATH_CANOPEN));
  wire is_ec    = (access_path_in == 2'(diag_record_pkg::PATH_ETHERCAT));
  wire sel_full = (is_rs && record_set_selector_in == `REC_SET_FULL)
               || (is_co && object_index_in == `OBJ_IDX_FULL);
  wire sel_short = (is_rs && record_set_selector_in == `REC_SET_SHORT)
                || (is_co && object_index_in == `OBJ_IDX_SHORT);
  wire [5:0] ec_pos = subidx_pos(object_subindex_in, byte_addr_in);
  wire sel_ec   = is_ec && object_index_in == `OBJ_IDX_ETHERCAT && ec_pos != 6'd63;
  wire ok_full  = sel_full && byte_addr_in < `FULL_LEN;
  wire ok_short = sel_short && byte_addr_in < `SHORT_LEN;
  wire [5:0] pos = sel_ec ? ec_pos : byte_addr_in;
  wire hit      = ok_full || ok_short || sel_ec;
  wire gen_pulse = gen_sync_q && !gen_prev_q;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      gen_meta_q  <= 1'b0;
      gen_sync_q  <= 1'b0;
      gen_prev_q  <= 1'b0;
      push_meta_q <= 1'b0;
      push_sync_q <= 1'b0;
      push_prev_q <= 1'b0;
    end else begin
      gen_meta_q  <= generate_in;
      gen_sync_q  <= gen_meta_q;
      gen_prev_q  <= gen_sync_q;
      push_meta_q <= entry_push_in;
      push_sync_q <= push_meta_q;
      push_prev_q <= push_sync_q;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      diag_timestamp_q <= 32'h0000_0000;
    end else if (gen_pulse) begin
      diag_timestamp_q <= ticker;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      read_valid_out <= 1'b0;
      read_error_out <= 1'b0;
      read_data_out  <= 8'h00;
    end else begin
      read_valid_out <= read_req_in && hit;
      read_error_out <= read_req_in && !hit;
      read_data_out  <= (read_req_in && hit) ? record_byte(pos, diag_timestamp_q) : 8'h00;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      outputs_out            <= 4'h0;
      queue_full_out         <= 1'b0;
      queued_entry_count_out <= 6'd0;
      last_sequence_out      <= 8'h00;
      schedule_done_out      <= 1'b0;
      irq_out                <= 1'b0;
    end else begin
      if (issued) begin
        outputs_out <= queued_img[7:4];
      end
      queue_full_out         <= q_full;
      queued_entry_count_out <= q_count;
      last_sequence_out      <= q_last;
      schedule_done_out      <= q_done;
      irq_out                <= 1'b0;
    end
  end

  AST_CLASS: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (read_req_in && ok_full && byte_addr_in == 6'd1) |=> read_data_out[3:0] == 4'hF)
    else $error("Class nibble is not digital.");
  AST_CHINFO: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (read_req_in && ok_full && byte_addr_in == 6'd1) |=> read_data_out[7:4] == 4'h1)
    else $error("Class upper bits wrong.");
  AST_KIND: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (read_req_in && ok_full && byte_addr_in == 6'd4) |=> read_data_out == 8'h72)
    else $error("Channel kind wrong.");
  AST_NBITS: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (read_req_in && ok_full && byte_addr_in == 6'd5) |=> read_data_out == 8'h00)
    else $error("Diagnostic bit count wrong.");
  AST_NCH: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (read_req_in && ok_full && byte_addr_in == 6'd6) |=> read_data_out == 8'h04)
    else $error("Channel count wrong.");
  AST_RSVD: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (read_req_in && ok_full && byte_addr_in >= 6'd7 && byte_addr_in <= 6'd19) |=> read_data_out == 8'h00)
    else $error("Reserved byte not zero.");
  AST_SHORT: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (read_req_in && is_rs && record_set_selector_in == 8'h00 && byte_addr_in == 6'd4) |=> read_error_out)
    else $error("Short record read past four bytes.");
  AST_FULL: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (read_req_in && is_co && object_index_in == 16'h2F01 && byte_addr_in == 6'd23) |=> read_valid_out)
    else $error("Full record byte refused.");
  AST_EC: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (read_req_in && is_ec && object_index_in == 16'h5005 && object_subindex_in == 8'h08) |=> read_data_out == 8'h04)
    else $error("EtherCAT subindex mapping wrong.");
  AST_TS: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    gen_pulse |=> diag_timestamp_q == $past(ticker))
    else $error("Timestamp not captured.");
  AST_NOIRQ: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !irq_out)
    else $error("Interrupt raised.");
  AST_ISSUE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    issued |=> outputs_out == $past(queued_img[7:4]))
    else $error("Issued state not driven.");
endmodule // output_module_diag_record
`default_nettype wire

//--- design/diag_record_params.svh
// Constants of the diagnostic record and the timed-output queue.
// Assumes inclusion by bare name from design files.
`ifndef DIAG_RECORD_PARAMS_SVH
`define DIAG_RECORD_PARAMS_SVH
`define REC_SET_SHORT        8'h00
`define REC_SET_FULL         8'h01
`define OBJ_IDX_SHORT        16'h2F00
`define OBJ_IDX_FULL         16'h2F01
`define OBJ_IDX_ETHERCAT     16'h5005
`define SUBIDX_FAULT_A       8'h02
`define SUBIDX_CLASS         8'h03
`define SUBIDX_FAULT_C       8'h04
`define SUBIDX_FAULT_D       8'h05
`define SUBIDX_KIND          8'h06
`define SUBIDX_DIAG_BITS     8'h07
`define SUBIDX_CH_COUNT      8'h08
`define SUBIDX_FAULT_SUM     8'h09
`define SUBIDX_CH_FAULT_LO   8'h0A
`define SUBIDX_CH_FAULT_HI   8'h11
`define SUBIDX_TIMESTAMP     8'h13
`define CLASS_DIGITAL        4'hF
`define CLASS_CH_INFO_BIT    4
`define CLASS_RESET          8'h1F
`define KIND_RESET           8'h72
`define DIAG_BITS_RESET      8'h00
`define CH_COUNT_RESET       8'h04
`define FAULT_RESET          8'h00
`define SHORT_LEN            6'd4
`define FULL_LEN             6'd24
`define TS_BYTE0             6'd20
`define FINAL_BIT            6
`define TICKS_PER_US_NUM     20
`endif

//--- design/diag_record_pkg.sv
// Types shared by the diagnostic record files.
// Assumes diag_record_params.svh for the numbers.
package diag_record_pkg;
  typedef enum logic [1:0] {
    PATH_RECORD_SET,
    PATH_CANOPEN,
    PATH_ETHERCAT
  } access_path_t;
  typedef enum logic [1:0] {
    Q_IDLE,
    Q_WAIT,
    Q_ISSUE
  } queue_state_t;
endpackage

//--- design/us_ticker.sv
// Microsecond time base derived from the module clock.
// Assumes a clock rate of a whole number of MHz.
`timescale 1ns/1ns
`default_nettype none
`include "diag_record_params.svh"
module us_ticker #(
  parameter int TICKS_PER_US = `TICKS_PER_US_NUM
) (
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  output logic      [31:0] us_count_out
);
  logic [7:0] div_q;
  wire        wrap = (div_q == 8'(TICKS_PER_US - 1));
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      div_q        <= 8'h00;
      us_count_out <= 32'h0000_0000;
    end else begin
      div_q        <= wrap ? 8'h00 : div_q + 8'h01;
      us_count_out <= wrap ? us_count_out + 32'h0000_0001 : us_count_out;
    end
  end
endmodule // us_ticker
`default_nettype wire

//--- design/timed_output_queue.sv
// Queue of timed output entries issued in push order, each when the time base reaches its entry time.
// Assumes entries arrive already ordered and the time base runs in microseconds.
`timescale 1ns/1ns
`default_nettype none
`include "diag_record_params.svh"
module timed_output_queue #(
  parameter int DEPTH = 32
) (
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        push_in,
  input  wire logic [7:0]  image_in,
  input  wire logic [7:0]  seq_in,
  input  wire logic [15:0] time_in,
  input  wire logic [15:0] now_in,
  output logic             full_out,
  output logic [7:0]       image_out,
  output logic             issue_out,
  output logic [7:0]       last_seq_out,
  output logic [5:0]       count_out,
  output logic             done_out
);
  localparam int AW = $clog2(DEPTH);
  logic [31:0]   mem [DEPTH];
  logic [AW-1:0] rd_q;
  logic [AW-1:0] wr_q;
  logic [5:0]    cnt_q;
  wire  [31:0]   head     = mem[rd_q];
  wire           nonempty = (cnt_q != 6'd0);
  wire           due      = nonempty && (head[15:0] == now_in);
  wire           take     = push_in && !full_out;
  wire           pop      = due;
  assign full_out = (cnt_q == 6'(DEPTH));
  assign count_out = cnt_q;
  always_ff @(posedge core_clk_in) begin
    if (take) begin
      mem[wr_q] <= {image_in, seq_in, time_in};
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rd_q         <= '0;
      wr_q         <= '0;
      cnt_q        <= 6'd0;
      image_out    <= 8'h00;
      issue_out    <= 1'b0;
      last_seq_out <= 8'h00;
      done_out     <= 1'b0;
    end else begin
      wr_q      <= take ? wr_q + 1'b1 : wr_q;
      rd_q      <= pop ? rd_q + 1'b1 : rd_q;
      cnt_q     <= cnt_q + 6'(take) - 6'(pop);
      issue_out <= pop;
      if (take) begin
        last_seq_out <= seq_in;
        done_out     <= 1'b0;
      end
      if (pop) begin
        image_out <= head[31:24];
        if (head[16+`FINAL_BIT]) begin
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule // timed_output_queue
`default_nettype wire

//--- test/head_bus_model.sv
// Behavioural head module that keeps a microsecond count, requests records and pushes schedule entries.
// Assumes the clock and synchronous reset of the module under test; its tasks are called at a falling edge.
`timescale 1ns/1ns
`default_nettype none
`include "diag_record_params.svh"
module head_bus_model (
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  output logic             generate_out,
  output logic             entry_push_out,
  output logic [7:0]       image_out,
  output logic [7:0]       seq_out,
  output logic [15:0]      time_out,
  output logic [31:0]      us_now_out
);
  int unsigned cycles = 0;
  // Microsecond time base kept in step with the module's own count.
  always @(posedge core_clk_in) begin
    cycles <= sys_rst_in ? 0 : cycles + 1;
  end
  assign us_now_out = cycles / `TICKS_PER_US_NUM;
  initial begin
    generate_out = 1'b0;
    entry_push_out = 1'b0;
    {image_out, seq_out, time_out} = 32'h0000_0000;
  end
  // Pushes one entry; the last of a short batch carries the final mark.
  task automatic push_entry(input logic [7:0] img, input logic [7:0] seq, input logic last, input logic [15:0] t);
    image_out = img;
    seq_out = seq | (8'(last) << `FINAL_BIT);
    time_out = t;
    repeat (2) @(negedge core_clk_in);
    entry_push_out = 1'b1;
    repeat (8) @(negedge core_clk_in);
    entry_push_out = 1'b0;
    {image_out, seq_out, time_out} = ~{image_out, seq_out, time_out};
    repeat (8) @(negedge core_clk_in);
  endtask
  // Raises the record request mid-microsecond so a short capture delay keeps the same count.
  task automatic raise_generate(output logic [31:0] us);
    while (cycles % `TICKS_PER_US_NUM != 8) @(negedge core_clk_in);
    us = us_now_out;
    generate_out = 1'b1;
    repeat (10) @(negedge core_clk_in);
    generate_out = 1'b0;
  endtask
endmodule // head_bus_model
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the diagnostic record and the timed-output queue.
// Assumes the design files and head_bus_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
  typedef struct packed {
    logic [1:0]  path;
    logic [7:0]  sel;
    logic [15:0] idx;
    logic [7:0]  sub;
    logic [5:0]  addr;
    logic        err;
    logic [7:0]  data;
  } row_t;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        read_req = 1'b0;
  row_t        cur = '0;
  logic        generate_sig, entry_push, read_valid, read_error, queue_full, schedule_done, irq;
  logic [7:0]  image, seq, read_data, last_sequence;
  logic [15:0] entry_time;
  logic [31:0] us_now, stamp;
  logic [3:0]  outputs;
  logic [5:0]  queued_count;
  logic        irq_seen = 1'b0;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  row_t rows [24] = '{
    '{2'h0, 8'h01, 16'h0, 8'h0, 6'h00, 1'h0, 8'h00},
    '{2'h0, 8'h01, 16'h0, 8'h0, 6'h01, 1'h0, 8'h1F},
    '{2'h0, 8'h01, 16'h0, 8'h0, 6'h04, 1'h0, 8'h72},
    '{2'h0, 8'h01, 16'h0, 8'h0, 6'h05, 1'h0, 8'h00},
    '{2'h0, 8'h01, 16'h0, 8'h0, 6'h06, 1'h0, 8'h04},
    '{2'h0, 8'h01, 16'h0, 8'h0, 6'h07, 1'h0, 8'h00},
    '{2'h0, 8'h01, 16'h0, 8'h0, 6'h0F, 1'h0, 8'h00},
    '{2'h0, 8'h01, 16'h0, 8'h0, 6'h17, 1'h0, 8'h00},
    '{2'h0, 8'h01, 16'h0, 8'h0, 6'h18, 1'h1, 8'h00},
    '{2'h0, 8'h00, 16'h0, 8'h0, 6'h01, 1'h0, 8'h1F},
    '{2'h0, 8'h00, 16'h0, 8'h0, 6'h04, 1'h1, 8'h00},
    '{2'h0, 8'h02, 16'h0, 8'h0, 6'h00, 1'h1, 8'h00},
    '{2'h1, 8'h0, 16'h2F01, 8'h0, 6'h06, 1'h0, 8'h04},
    '{2'h1, 8'h0, 16'h2F00, 8'h0, 6'h01, 1'h0, 8'h1F},
    '{2'h1, 8'h0, 16'h2F00, 8'h0, 6'h04, 1'h1, 8'h00},
    '{2'h1, 8'h0, 16'h2F02, 8'h0, 6'h00, 1'h1, 8'h00},
    '{2'h1, 8'h0, 16'h2F01, 8'h0, 6'h17, 1'h0, 8'h00},
    '{2'h2, 8'h0, 16'h5005, 8'h08, 6'h00, 1'h0, 8'h04},
    '{2'h2, 8'h0, 16'h5005, 8'h03, 6'h00, 1'h0, 8'h1F},
    '{2'h2, 8'h0, 16'h5005, 8'h06, 6'h00, 1'h0, 8'h72},
    '{2'h2, 8'h0, 16'h5005, 8'h11, 6'h00, 1'h0, 8'h00},
    '{2'h2, 8'h0, 16'h5005, 8'h13, 6'h03, 1'h0, 8'h00},
    '{2'h2, 8'h0, 16'h5005, 8'h12, 6'h00, 1'h1, 8'h00},
    '{2'h2, 8'h0, 16'h5006, 8'h03, 6'h00, 1'h1, 8'h00}
  };
  always #25 core_clk = ~core_clk;
  head_bus_model head_bus_model_inst (
    .core_clk_in    (core_clk),
    .sys_rst_in     (sys_rst),
    .generate_out   (generate_sig),
    .entry_push_out (entry_push),
    .image_out      (image),
    .seq_out        (seq),
    .time_out       (entry_time),
    .us_now_out     (us_now)
  );
  output_module_diag_record output_module_diag_record_inst (
    .core_clk_in              (core_clk),
    .sys_rst_in               (sys_rst),
    .read_req_in              (read_req),
    .access_path_in           (cur.path),
    .record_set_selector_in   (cur.sel),
    .object_index_in          (cur.idx),
    .object_subindex_in       (cur.sub),
    .byte_addr_in             (cur.addr),
    .generate_in              (generate_sig),
    .entry_push_in            (entry_push),
    .output_image_byte_in     (image),
    .entry_sequence_number_in (seq),
    .entry_time_in            (entry_time),
    .read_valid_out           (read_valid),
    .read_error_out           (read_error),
    .read_data_out            (read_data),
    .outputs_out              (outputs),
    .queue_full_out           (queue_full),
    .queued_entry_count_out   (queued_count),
    .last_sequence_out        (last_sequence),
    .schedule_done_out        (schedule_done),
    .irq_out                  (irq)
  );
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  always @(negedge core_clk) begin
    if (!sys_rst && irq !== 1'b0) irq_seen <= 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Drives one request at a falling edge and checks the one-cycle answer; the request stays up for back-to-back use.
  task automatic rd(input row_t r);
    cur = r;
    read_req = 1'b1;
    @(negedge core_clk);
    chk(32'(read_error), 32'(r.err));
    chk(32'(read_valid), 32'(!r.err));
    chk(32'(read_data), 32'(r.data));
  endtask
  // Waits for the entry's microsecond, then checks it was not issued early and has been issued three falling edges later.
  task automatic wait_issue(input logic [15:0] t, input logic [3:0] outs, input logic [5:0] left);
    int i;
    for (i = 0; i < 2000 && us_now[15:0] != t; i++) @(negedge core_clk);
    chk(32'(queued_count), 32'(left) + 32'h1);
    repeat (3) @(negedge core_clk);
    chk(32'(outputs), 32'(outs));
    chk(32'(queued_count), 32'(left));
    chk(32'(last_sequence), 32'h43);
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    chk(32'({read_valid, read_error, outputs, queued_count, schedule_done, irq}), 32'h0);
    $display("test reset done");
    foreach (rows[k]) rd(rows[k]);
    read_req = 1'b0;
    @(negedge core_clk);
    chk(32'(read_valid), 32'h0);
    $display("test record table done");
    head_bus_model_inst.raise_generate(stamp);
    repeat (4) @(negedge core_clk);
    for (int i = 0; i < 4; i++) begin
      rd('{2'h0, 8'h01, 16'h0, 8'h0, 6'(20 + i), 1'h0, stamp[8*i+:8]});
      rd('{2'h2, 8'h0, 16'h5005, 8'h13, 6'(i), 1'h0, stamp[8*i+:8]});
    end
    read_req = 1'b0;
    @(negedge core_clk);
    $display("test timestamp done");
    stamp = us_now + 32'h0000_001E;
    head_bus_model_inst.push_entry(8'hF0, 8'h01, 1'b0, stamp[15:0]);
    head_bus_model_inst.push_entry(8'h30, 8'h02, 1'b0, stamp[15:0] + 16'h000A);
    head_bus_model_inst.push_entry(8'hA0, 8'h03, 1'b1, stamp[15:0] + 16'h0014);
    chk({26'h0, queued_count}, 32'h3);
    chk({28'h0, outputs}, 32'h0);
    chk(32'(schedule_done), 32'h0);
    chk(32'(queue_full), 32'h0);
    wait_issue(stamp[15:0], 4'hF, 6'h02);
    wait_issue(stamp[15:0] + 16'h000A, 4'h3, 6'h01);
    chk(32'(schedule_done), 32'h0);
    wait_issue(stamp[15:0] + 16'h0014, 4'hA, 6'h00);
    chk(32'(schedule_done), 32'h1);
    chk(32'(irq_seen), 32'h0);
    $display("test queue done");
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
